// ==== pkg/lmm_pkg.sv ====
// Shared constants and types for the literal, move and multiply execute block.
package lmm_pkg;

  // ****************************************************************
  // Opcode patterns
  // ****************************************************************
  localparam logic [7:0] OPC_LOAD_BANK = 8'h01;
  localparam logic [7:0] OPC_LOAD_ACC = 8'h0E;
  localparam logic [7:0] OPC_MULTIPLY = 8'h0D;
  localparam logic [6:0] OPC_STORE = 7'h37;

  // ****************************************************************
  // Instruction word fields
  // ****************************************************************
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 8;
  localparam int STORE_OPC_LO = 9;
  localparam int ACCESS_BIT = 8;
  localparam int OPERAND_HI = 7;
  localparam int OPERAND_LO = 0;
  localparam int NIBBLE_HI = 3;
  localparam int INSTR_W = 16;

  // ****************************************************************
  // Data memory addressing
  // ****************************************************************
  localparam logic [7:0] INDEXED_MAX = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0] BANK_UPPER_ZERO = 4'h0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PROD_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PH_Q1,
    PH_Q2,
    PH_Q3,
    PH_Q4
  } lmm_phase_e;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_LOAD_BANK,
    OP_LOAD_ACC,
    OP_STORE,
    OP_MULTIPLY
  } lmm_op_e;

  typedef struct packed {
    logic wr_en;
    logic indexed;
    logic [11:0] addr;
    logic [7:0] data;
  } lmm_mem_req_s;

  localparam lmm_mem_req_s MEM_REQ_IDLE = '{wr_en: 1'b0, indexed: 1'b0, addr: 12'h000,
                                            data: 8'h00};

endpackage

// ==== logic/lmm_exec.sv ====
// Execute logic for bank load, accumulator load, accumulator store and literal multiply.
module lmm_exec #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk, // Core clock, one phase per cycle.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [15:0] instr_word, // Fetched instruction, sampled in Q1.
  input wire logic instr_valid, // Instruction word is valid in Q1.
  input wire logic ext_set_en, // Extended instruction set enabled.
  output logic [1:0] phase, // Current phase, 0 is Q1.
  output logic [7:0] acc, // Accumulator.
  output logic [7:0] bank_select_reg, // Bank select register.
  output logic [7:0] product_high, // Product high byte.
  output logic [7:0] product_low, // Product low byte.
  output lmm_pkg::lmm_mem_req_s mem_req, // Data memory write request, valid in Q4.
  output logic instr_done // Pulse in the Q1 after a recognised instruction.
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (ADDR_W != 12) begin : g_bad_addr
    $error("lmm_exec: ADDR_W must be 12");
  end

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // Phase sequencer
  // ****************************************************************
  lmm_pkg::lmm_phase_e phase_reg;

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      phase_reg <= lmm_pkg::PH_Q1;
    end else begin
      unique case (phase_reg)
        lmm_pkg::PH_Q1: phase_reg <= lmm_pkg::PH_Q2;
        lmm_pkg::PH_Q2: phase_reg <= lmm_pkg::PH_Q3;
        lmm_pkg::PH_Q3: phase_reg <= lmm_pkg::PH_Q4;
        lmm_pkg::PH_Q4: phase_reg <= lmm_pkg::PH_Q1;
      endcase
    end
  end

  assign phase = phase_reg;

  // ****************************************************************
  // Decode in Q1
  // ****************************************************************
  lmm_pkg::lmm_op_e op_reg;
  lmm_pkg::lmm_op_e op_next;
  logic [15:0] ir_reg;

  always_comb begin
    op_next = lmm_pkg::OP_NONE;
    if (instr_valid) begin
      unique case (instr_word[lmm_pkg::OPC_HI:lmm_pkg::OPC_LO])
        lmm_pkg::OPC_LOAD_BANK: op_next = lmm_pkg::OP_LOAD_BANK;
        lmm_pkg::OPC_LOAD_ACC: op_next = lmm_pkg::OP_LOAD_ACC;
        lmm_pkg::OPC_MULTIPLY: op_next = lmm_pkg::OP_MULTIPLY;
        default: begin
          if (instr_word[lmm_pkg::OPC_HI:lmm_pkg::STORE_OPC_LO] == lmm_pkg::OPC_STORE) begin
            op_next = lmm_pkg::OP_STORE;
          end
        end
      endcase
    end
  end

  // Opcode and word are held for the whole cycle so later phases see a stable operand.
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      op_reg <= lmm_pkg::OP_NONE;
      ir_reg <= lmm_pkg::WORD_RESET;
    end else if (phase_reg == lmm_pkg::PH_Q1) begin
      op_reg <= op_next;
      ir_reg <= instr_word;
    end
  end

  // ****************************************************************
  // Operand read in Q2
  // ****************************************************************
  logic [7:0] acc_reg;
  logic [7:0] lit_reg;
  logic [7:0] store_data_reg;

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      lit_reg <= lmm_pkg::ACC_RESET;
      store_data_reg <= lmm_pkg::ACC_RESET;
    end else if (phase_reg == lmm_pkg::PH_Q2) begin
      lit_reg <= ir_reg[lmm_pkg::OPERAND_HI:lmm_pkg::OPERAND_LO];
      store_data_reg <= acc_reg;
    end
  end

  // ****************************************************************
  // Compute in Q3
  // ****************************************************************
  logic [15:0] prod_calc_reg;
  lmm_pkg::lmm_mem_req_s mem_req_next;
  lmm_pkg::lmm_mem_req_s mem_req_reg;
  logic [7:0] file_addr;
  logic access_sel;

  assign file_addr = ir_reg[lmm_pkg::OPERAND_HI:lmm_pkg::OPERAND_LO];
  assign access_sel = ir_reg[lmm_pkg::ACCESS_BIT];

  // The indexed case hands out only the literal offset; the pointer add lives elsewhere.
  always_comb begin
    mem_req_next = lmm_pkg::MEM_REQ_IDLE;
    mem_req_next.data = store_data_reg;
    if (access_sel) begin
      mem_req_next.addr = {bank_select_reg[lmm_pkg::NIBBLE_HI:0], file_addr};
    end else if (ext_set_en && file_addr <= lmm_pkg::INDEXED_MAX) begin
      mem_req_next.indexed = 1'b1;
      mem_req_next.addr = {lmm_pkg::ACCESS_LOW_BANK, file_addr};
    end else if (file_addr < lmm_pkg::ACCESS_SPLIT) begin
      mem_req_next.addr = {lmm_pkg::ACCESS_LOW_BANK, file_addr};
    end else begin
      mem_req_next.addr = {lmm_pkg::ACCESS_HIGH_BANK, file_addr};
    end
    mem_req_next.wr_en = (op_reg == lmm_pkg::OP_STORE);
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      prod_calc_reg <= {lmm_pkg::PROD_RESET, lmm_pkg::PROD_RESET};
    end else if (phase_reg == lmm_pkg::PH_Q3 && op_reg == lmm_pkg::OP_MULTIPLY) begin
      prod_calc_reg <= 16'(acc_reg) * 16'(lit_reg);
    end
  end

  // The write request is raised at the end of Q3 so memory sees it for all of Q4.
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      mem_req_reg <= lmm_pkg::MEM_REQ_IDLE;
    end else if (phase_reg == lmm_pkg::PH_Q3) begin
      mem_req_reg <= mem_req_next;
    end else begin
      mem_req_reg.wr_en <= 1'b0;
    end
  end

  assign mem_req = mem_req_reg;

  // ****************************************************************
  // Write-back in Q4
  // ****************************************************************
  logic [7:0] bank_reg;
  logic [7:0] prod_high_reg;
  logic [7:0] prod_low_reg;
  logic done_reg;

  // No status flag output exists: none of these instructions may touch the flags.
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      bank_reg <= lmm_pkg::BANK_RESET;
    end else if (phase_reg == lmm_pkg::PH_Q4 && op_reg == lmm_pkg::OP_LOAD_BANK) begin
      bank_reg <= {lmm_pkg::BANK_UPPER_ZERO, lit_reg[lmm_pkg::NIBBLE_HI:0]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      acc_reg <= lmm_pkg::ACC_RESET;
    end else if (phase_reg == lmm_pkg::PH_Q4 && op_reg == lmm_pkg::OP_LOAD_ACC) begin
      acc_reg <= lit_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      prod_high_reg <= lmm_pkg::PROD_RESET;
      prod_low_reg <= lmm_pkg::PROD_RESET;
    end else if (phase_reg == lmm_pkg::PH_Q4 && op_reg == lmm_pkg::OP_MULTIPLY) begin
      prod_high_reg <= prod_calc_reg[15:8];
      prod_low_reg <= prod_calc_reg[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (phase_reg == lmm_pkg::PH_Q4) && (op_reg != lmm_pkg::OP_NONE);
    end
  end

  assign acc = acc_reg;
  assign bank_select_reg = bank_reg;
  assign product_high = prod_high_reg;
  assign product_low = prod_low_reg;
  assign instr_done = done_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_decode(logic [7:0] opc);
    phase_reg == lmm_pkg::PH_Q1 && instr_valid && instr_word[15:8] == opc;
  endsequence

  sequence s_finish;
    ##3 phase_reg == lmm_pkg::PH_Q4 ##1 done_reg;
  endsequence

  bank_upper_zero_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    bank_reg[7:4] == 4'h0)
    else $error("bank register upper nibble not zero");

  bank_load_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    s_decode(8'h01) |-> ##4 bank_reg == {4'h0, $past(instr_word[3:0], 4)})
    else $error("bank load wrote wrong value or at wrong time");

  acc_load_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    s_decode(8'h0E) |-> ##3 $stable(acc_reg) ##1 acc_reg == $past(instr_word[7:0], 4))
    else $error("accumulator load wrong");

  cycle_done_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    s_decode(8'h0D) |-> s_finish)
    else $error("multiply did not finish in one instruction cycle");

  mul_result_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    s_decode(8'h0D) |-> ##4 {prod_high_reg, prod_low_reg} ==
      16'($past(acc_reg, 4)) * 16'($past(instr_word[7:0], 4)) &&
      acc_reg == $past(acc_reg, 4))
    else $error("multiply product wrong or accumulator changed");

  store_write_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    phase_reg == lmm_pkg::PH_Q3 && op_reg == lmm_pkg::OP_STORE |=>
      mem_req_reg.wr_en && mem_req_reg.data == acc_reg)
    else $error("store did not write the accumulator in Q4");

  store_banked_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    phase_reg == lmm_pkg::PH_Q3 && op_reg == lmm_pkg::OP_STORE && ir_reg[8] |=>
      mem_req_reg.addr == {$past(bank_reg[3:0]), $past(ir_reg[7:0])} && !mem_req_reg.indexed)
    else $error("banked store address wrong");

  store_indexed_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    phase_reg == lmm_pkg::PH_Q3 && op_reg == lmm_pkg::OP_STORE |=>
      mem_req_reg.indexed == ($past(!ir_reg[8] && ext_set_en) && $past(ir_reg[7:0]) <= 8'h5F))
    else $error("indexed selection wrong");

  write_phase_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    mem_req_reg.wr_en |-> phase_reg == lmm_pkg::PH_Q4 ##1 !mem_req_reg.wr_en)
    else $error("memory write outside Q4 or longer than one cycle");

  // Architectural registers may only move at the edge that closes Q4.
  bank_q4_only_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    phase_reg != lmm_pkg::PH_Q4 |=> $stable(bank_reg))
    else $error("bank register changed outside Q4 write-back");

  acc_q4_only_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    phase_reg != lmm_pkg::PH_Q4 |=> $stable(acc_reg))
    else $error("accumulator changed outside Q4 write-back");

  prod_q4_only_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    phase_reg != lmm_pkg::PH_Q4 |=> $stable({prod_high_reg, prod_low_reg}))
    else $error("product pair changed outside Q4 write-back");

  store_only_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    phase_reg == lmm_pkg::PH_Q3 && op_reg != lmm_pkg::OP_STORE |=> !mem_req_reg.wr_en)
    else $error("memory write raised by an instruction other than a store");

  done_pulse_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    done_reg |-> phase_reg == lmm_pkg::PH_Q1 ##1 !done_reg)
    else $error("completion pulse not a single Q1 cycle");

endmodule

// ==== bench/lmm_data_mem_model.sv ====
// Behavioural data memory that takes the write requests of the execute block.
module lmm_data_mem_model (
  input wire logic ref_clk, // Core clock.
  input wire logic rst_n, // Reset, active low.
  input wire lmm_pkg::lmm_mem_req_s mem_req, // Write request from the block.
  output logic wr_seen, // Pulse in the cycle after a write landed.
  output lmm_pkg::lmm_mem_req_s last_wr, // Copy of the request that landed.
  output logic [7:0] rd_back // Memory byte at the last written address.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_reg [0:4095];
  // Read back from the array at the address the request named, so the byte that landed there is checked.
  assign rd_back = mem_reg[last_wr.addr];
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_seen <= 1'b0;
      last_wr <= lmm_pkg::MEM_REQ_IDLE;
    end else begin
      wr_seen <= mem_req.wr_en;
      if (mem_req.wr_en) begin
        mem_reg[mem_req.addr] <= mem_req.data;
        last_wr <= mem_req;
      end
    end
  end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the literal, move and multiply execute block.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] acc; logic [7:0] bank; logic [15:0] prod; int due;} lmm_exp_s;
  logic ref_clk, rst_n, instr_valid, ext_set_en, instr_done, wr_seen;
  logic [15:0] instr_word;
  logic [1:0] phase;
  logic [7:0] acc, bank_select_reg, product_high, product_low, rd_back, rk, acc_m, bank_m;
  logic [15:0] prod_m;
  logic [31:0] seed;
  lmm_pkg::lmm_mem_req_s mem_req, last_wr, sgot;
  lmm_exp_s got;
  lmm_exp_s exp_q[$];
  lmm_pkg::lmm_mem_req_s st_q[$];
  int failures, tests_run;
  int cyc = 0;
  logic [16:0] st_tab [9] = '{17'h06F00, 17'h06FFF, 17'h06E00, 17'h06E5F, 17'h06E60,
                              17'h06EFF, 17'h16E5F, 17'h16E60, 17'h16E00};
  logic [15:0] bad_tab [6] = '{16'h0000, 16'h02AB, 16'h6CFF, 16'h0FAA, 16'h6A12, 16'hFFFF};

  lmm_exec dut (.ref_clk(ref_clk), .rst_n(rst_n), .instr_word(instr_word),
    .instr_valid(instr_valid), .ext_set_en(ext_set_en), .phase(phase), .acc(acc),
    .bank_select_reg(bank_select_reg), .product_high(product_high),
    .product_low(product_low), .mem_req(mem_req), .instr_done(instr_done));
  lmm_data_mem_model mem (.ref_clk(ref_clk), .rst_n(rst_n), .mem_req(mem_req),
    .wr_seen(wr_seen), .last_wr(last_wr), .rd_back(rd_back));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] expv, input string what);
    tests_run++;
    if (seen !== expv) begin
      failures++;
      $display("ERROR t=%0t %s seen %0h expected %0h", $time, what, seen, expv);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // The bound covers some sixty instructions of four cycles with ample slack.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      $display("ERROR t=%0t run timed out", $time);
      results();
    end
  end

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic rnd8(output logic [7:0] v);
    seed = xs(seed);
    v = seed[7:0];
  endtask

  function automatic lmm_pkg::lmm_mem_req_s store_exp(input logic a, input logic [7:0] f,
                                                      input logic ext);
    lmm_pkg::lmm_mem_req_s r;
    r.wr_en = 1'b1;
    r.data = acc_m;
    r.indexed = !a && ext && f <= 8'h5F;
    if (a) r.addr = {bank_m[3:0], f};
    else if (f < lmm_pkg::ACCESS_SPLIT || r.indexed) r.addr = {4'h0, f};
    else r.addr = {lmm_pkg::ACCESS_HIGH_BANK, f};
    return r;
  endfunction

  // Drives one word in the coming Q1, then puts a valid junk word on the port for Q2..Q4.
  task automatic issue(input logic [15:0] w, input logic ext);
    lmm_exp_s e;
    logic [7:0] k;
    k = w[7:0];
    do @(negedge ref_clk); while (phase !== 2'd3);
    e.due = cyc + 5;
    @(posedge ref_clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    ext_set_en <= ext;
    case (w[15:8])
      8'h01: bank_m = {4'h0, k[3:0]};
      8'h0E: acc_m = k;
      8'h0D: prod_m = acc_m * k;
      8'h6E, 8'h6F: st_q.push_back(store_exp(w[8], k, ext));
      default: e.due = -1;
    endcase
    e.acc = acc_m;
    e.bank = bank_m;
    e.prod = prod_m;
    if (e.due >= 0) exp_q.push_back(e);
    @(posedge ref_clk);
    rnd8(k);
    instr_word <= {8'h0E, k};
  endtask

  // ****************************************************************
  // Result watcher
  // ****************************************************************
  always @(negedge ref_clk) begin
    if (rst_n === 1'b1 && instr_done === 1'b1) begin
      if (exp_q.size() == 0) check(1, 0, "unexpected completion");
      else begin
        got = exp_q.pop_front();
        check(cyc, got.due, "completion time");
        check(acc, got.acc, "accumulator");
        check(bank_select_reg, got.bank, "bank register");
        check({product_high, product_low}, got.prod, "product");
      end
    end
    if (mem_req.wr_en === 1'b1) check(phase, 3, "write phase");
    if (wr_seen === 1'b1) begin
      if (st_q.size() == 0) check(1, 0, "unexpected write");
      else begin
        sgot = st_q.pop_front();
        check(last_wr, sgot, "store request");
        check(rd_back, sgot.data, "memory byte");
      end
    end
  end

  initial begin
    instr_word = 16'h0000;
    instr_valid = 1'b0;
    ext_set_en = 1'b0;
    rst_n = 1'b0;
    seed = 32'h00008AD1;
    failures = 0;
    tests_run = 0;
    acc_m = 8'h00;
    bank_m = 8'h00;
    prod_m = 16'h0000;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rnd8(rk);
      issue({8'h01, i[3:0], rk[3:0]}, 1'b0);
    end
    $display("bank load test done");
    issue(16'h0E00, 1'b0);
    issue(16'h0EFF, 1'b0);
    issue(16'h0EE2, 1'b0);
    issue(16'h0DC4, 1'b0);
    issue(16'h0EFF, 1'b0);
    issue(16'h0DFF, 1'b0);
    issue(16'h0D00, 1'b0);
    for (int i = 0; i < 6; i++) begin
      rnd8(rk);
      issue({8'h0E, rk}, 1'b0);
      rnd8(rk);
      issue({8'h0D, rk}, 1'b0);
    end
    $display("load and multiply test done");
    issue(16'h01A7, 1'b0);
    foreach (st_tab[i]) begin
      rnd8(rk);
      issue({8'h0E, rk}, 1'b0);
      issue(st_tab[i][15:0], st_tab[i][16]);
    end
    $display("store test done");
    foreach (bad_tab[i]) issue(bad_tab[i], 1'b1);
    issue(16'h0E3C, 1'b0);
    do @(negedge ref_clk); while (phase !== 2'd3);
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check(exp_q.size(), 0, "missing completions");
    check(st_q.size(), 0, "missing writes");
    $display("unknown opcode test done");
    results();
  end
endmodule
